//--- logic/cpu_bus_exception.sv
`timescale 1ns/1ps
// ***************************************************************
// Overview of operation
// - no acknowledge in time: own bus fault
// - acknowledge alone: normal end, continue
// - halt with acknowledge: end, then hold bus
// - fault without halt: end, fault exception
// - fault one clock after acknowledge: fault
// - fault beats acknowledge, data discarded
// - late fault sampled one clock after acknowledge
// - fault plus halt: retry, not exception
// - retry: strobes idle until both negated
// - after sync delay rerun same access
// - far side drops fault after strobe negates
// - far side drops fault before rerun strobe
// - far side drops acknowledge before next cycle
// - far side changes pins on clock edges
// - fault before acknowledge: cycle ends a clock sooner
// - prefetch fault pending until word used or flushed
// - locked sequence: lock held through retry
// - request with retry: grant bus first
// - no bus release inside locked sequence
// ***************************************************************
module cpu_bus_exception
	import bus_exc_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              srst,
	bus_exc_if.cpu                 bus,
	input  wire logic              start,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [FC_W-1:0]   fc,
	input  wire logic [SIZE_W-1:0] size,
	input  wire logic              write,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic              prefetch,
	input  wire logic              lock_seq,
	input  wire logic              word_used,
	input  wire logic              word_flush,
	output logic                   busy,
	output logic                   done,
	output outcome_type            outcome,
	output logic [DATA_W-1:0]      rdata,
	output logic                   fault_exc,
	output logic                   prefetch_fault_pending
);
	// ***************************************************************
	// state
	// ***************************************************************
	cycle_state_type   state;
	cycle_state_type   next_state;
	outcome_type       res;
	outcome_type       next_res;
	logic              halt_seen;
	logic              relinq;
	logic              pf_cycle;
	logic              lock_hold;
	logic [DATA_W-1:0] held_data;
	logic [SYNC_W-1:0] sync_cnt;
	logic              tmo;

	// ***************************************************************
	// pin decode
	// ***************************************************************
	wire vec_cycle  = (bus.fc == FC_CPU_SPACE);
	wire ack_in     = (bus.size_ack_n != ACK_NONE) || (vec_cycle && !bus.auto_vector_n);
	wire fault_pin  = !bus.bus_fault_n;
	wire fault_in   = fault_pin || tmo;
	wire halt_in    = !bus.halt_n;
	wire req_in     = !bus.bus_req_n;
	wire owned_in   = !bus.bus_grant_ack_n;
	wire in_wait    = (state == ST_WAIT);
	wire in_late    = (state == ST_LATE);
	wire in_end     = (state == ST_END);

	// fault is checked first so it wins over a same-edge acknowledge
	wire wait_fault = in_wait && fault_in;
	wire wait_ack   = in_wait && !fault_in && ack_in;
	wire late_fault = in_late && fault_pin;
	wire retry_now  = (wait_fault || late_fault) && halt_in;
	// a locked sequence never gives the bus away, even when asked to
	wire want_rel   = retry_now && req_in && !lock_hold;
	wire fault_end  = in_end && (res == OUT_FAULT);
	wire data_ok    = in_end && (res == OUT_NORMAL || res == OUT_HALT);
	wire cycle_done = in_end && (res == OUT_NORMAL || res == OUT_FAULT || res == OUT_HALT);
	wire pins_clear = !fault_pin && !halt_in;
	wire sync_done  = (sync_cnt == SYNC_LAST);
	wire strobe_on  = (next_state == ST_WAIT) || (next_state == ST_LATE);

	assign next_res = retry_now  ? OUT_RETRY :
	                  (wait_fault || late_fault) ? OUT_FAULT :
	                  halt_seen  ? OUT_HALT :
	                  OUT_NORMAL;

	// ***************************************************************
	// sequencing
	// ***************************************************************
	always_comb
	begin
		next_state = state;
		case (state)
			ST_IDLE:  next_state = start ? ST_ADDR : ST_IDLE;
			ST_ADDR:  next_state = ST_WAIT;
			ST_WAIT:  next_state = wait_fault ? ST_END : (wait_ack ? ST_LATE : ST_WAIT);
			// one extra clock gives a late fault its sampling edge
			ST_LATE:  next_state = ST_END;
			ST_END:
			begin
				case (res)
					OUT_HALT:  next_state = ST_HALT;
					OUT_RETRY: next_state = ST_RETRY;
					default:   next_state = ST_IDLE;
				endcase
			end
			ST_HALT:  next_state = halt_in ? ST_HALT : ST_IDLE;
			ST_RETRY: next_state = !pins_clear ? ST_RETRY : (relinq ? ST_GRANT : ST_SYNC);
			ST_GRANT: next_state = (req_in || owned_in) ? ST_GRANT : ST_SYNC;
			ST_SYNC:  next_state = sync_done ? ST_ADDR : ST_SYNC;
			default:  next_state = ST_IDLE;
		endcase
	end

	bus_watchdog bus_watchdog_i (
		.ref_clk (ref_clk),
		.srst    (srst),
		.run     (in_wait),
		.expired (tmo)
	);

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			state     <= ST_IDLE;
			res       <= OUT_NORMAL;
			halt_seen <= 1'b0;
			relinq    <= 1'b0;
			sync_cnt  <= '0;
		end
		else
		begin
			state     <= next_state;
			if (wait_fault || in_late)
				res <= next_res;
			if (state == ST_ADDR)
				halt_seen <= 1'b0;
			else if (wait_ack)
				halt_seen <= halt_in;
			if (retry_now)
				relinq <= want_rel;
			sync_cnt  <= (state == ST_SYNC) ? SYNC_W'(sync_cnt + 1'b1) : '0;
		end
	end

	// ***************************************************************
	// access attributes, held untouched across a retry
	// ***************************************************************
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			bus.addr     <= '0;
			bus.fc       <= '0;
			bus.size     <= '0;
			bus.rw       <= NEGATED;
			bus.data_out <= '0;
			pf_cycle     <= 1'b0;
		end
		else if (state == ST_IDLE && start)
		begin
			bus.addr     <= addr;
			bus.fc       <= fc;
			bus.size     <= size;
			bus.rw       <= !write;
			bus.data_out <= wdata;
			pf_cycle     <= prefetch;
		end
	end

	// ***************************************************************
	// pins and user results
	// ***************************************************************
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			bus.addr_strobe_n  <= NEGATED;
			bus.bus_grant_n    <= NEGATED;
			bus.locked_cycle_n <= NEGATED;
			lock_hold          <= 1'b0;
			held_data          <= '0;
			rdata              <= '0;
			busy               <= 1'b0;
			done               <= 1'b0;
			outcome            <= OUT_NORMAL;
			fault_exc          <= 1'b0;
			prefetch_fault_pending <= 1'b0;
		end
		else
		begin
			bus.addr_strobe_n  <= !strobe_on;
			bus.bus_grant_n    <= !(next_state == ST_GRANT);
			// released only between operations, never mid retry
			if (state == ST_IDLE)
				lock_hold <= start && lock_seq;
			else if (lock_seq)
				lock_hold <= 1'b1;
			bus.locked_cycle_n <= !(lock_hold || (state == ST_IDLE && start && lock_seq));
			if (wait_ack)
				held_data <= bus.data_in;
			if (data_ok && bus.rw)
				rdata <= held_data;
			busy    <= (next_state != ST_IDLE);
			done    <= cycle_done;
			if (in_end)
				outcome <= res;
			// a new fault outranks a flush landing on the same edge
			fault_exc <= (fault_end && !pf_cycle) ||
			             (prefetch_fault_pending && word_used && !word_flush);
			prefetch_fault_pending <= (fault_end && pf_cycle) ||
			             (prefetch_fault_pending && !word_used && !word_flush);
		end
	end
endmodule : cpu_bus_exception

//--- inc/bus_exc_pkg.sv
package bus_exc_pkg;
	// ***************************************************************
	// widths
	// ***************************************************************
	localparam int ADDR_W = 32;
	localparam int DATA_W = 16;
	localparam int FC_W   = 3;
	localparam int SIZE_W = 2;
	localparam int ACK_W  = 2;
	localparam int WAIT_W = 4;

	// ***************************************************************
	// pin levels and codes
	// ***************************************************************
	localparam logic             ASSERTED     = 1'b0;
	localparam logic             NEGATED      = 1'b1;
	localparam logic [ACK_W-1:0] ACK_NONE     = 2'h3;
	localparam logic [ACK_W-1:0] ACK_PORT16   = 2'h1;
	localparam logic [FC_W-1:0]  FC_CPU_SPACE = 3'h7;

	// ***************************************************************
	// timing
	// ***************************************************************
	localparam int CLK_MHZ        = 200;
	localparam int BUS_TIMEOUT_NS = 640;
	localparam int SYNC_DELAY_NS  = 10;
	// longest wait rounds down, least delay rounds up
	localparam int TIMEOUT_CYCLES = (BUS_TIMEOUT_NS * CLK_MHZ) / 1000;
	localparam int SYNC_CYCLES    = (SYNC_DELAY_NS * CLK_MHZ + 999) / 1000;
	localparam int TMO_W          = $clog2(TIMEOUT_CYCLES + 1);
	localparam int SYNC_W         = $clog2(SYNC_CYCLES + 1);
	localparam logic [TMO_W-1:0]  TMO_LAST  = TMO_W'(TIMEOUT_CYCLES - 1);
	localparam logic [SYNC_W-1:0] SYNC_LAST = SYNC_W'(SYNC_CYCLES - 1);

	// ***************************************************************
	// types
	// ***************************************************************
	typedef enum logic [1:0] {OUT_NORMAL, OUT_HALT, OUT_FAULT, OUT_RETRY} outcome_type;

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_WAIT, ST_LATE, ST_END,
		ST_HALT, ST_RETRY, ST_GRANT, ST_SYNC
	} cycle_state_type;

	typedef enum logic [2:0] {
		RESP_NORMAL, RESP_HALT, RESP_FAULT, RESP_LATE_FAULT,
		RESP_RETRY, RESP_LATE_RETRY, RESP_AUTOVEC, RESP_SILENT
	} resp_type;
endpackage : bus_exc_pkg

//--- inc/bus_exc_if.sv
`timescale 1ns/1ps
interface bus_exc_if;
	import bus_exc_pkg::*;
	logic [ADDR_W-1:0] addr;
	logic [FC_W-1:0]   fc;
	logic [SIZE_W-1:0] size;
	logic              rw;
	logic [DATA_W-1:0] data_out;
	logic [DATA_W-1:0] data_in;
	logic              addr_strobe_n;
	logic              locked_cycle_n;
	logic              bus_grant_n;
	logic [ACK_W-1:0]  size_ack_n;
	logic              bus_fault_n;
	logic              halt_n;
	logic              auto_vector_n;
	logic              bus_req_n;
	logic              bus_grant_ack_n;

	modport cpu (
		output addr, fc, size, rw, data_out, addr_strobe_n, locked_cycle_n, bus_grant_n,
		input  data_in, size_ack_n, bus_fault_n, halt_n, auto_vector_n, bus_req_n,
		input  bus_grant_ack_n
	);
	modport far (
		input  addr, fc, size, rw, data_out, addr_strobe_n, locked_cycle_n, bus_grant_n,
		output data_in, size_ack_n, bus_fault_n, halt_n, auto_vector_n, bus_req_n,
		output bus_grant_ack_n
	);
endinterface : bus_exc_if

//--- logic/bus_watchdog.sv
`timescale 1ns/1ps
module bus_watchdog
	import bus_exc_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic srst,
	input  wire logic run,
	output logic      expired
);
	logic [TMO_W-1:0] count;

	wire hit_last = run && (count == TMO_LAST);

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			count   <= '0;
			expired <= 1'b0;
		end
		else
		begin
			count   <= run ? TMO_W'(count + 1'b1) : '0;
			expired <= hit_last;
		end
	end
endmodule : bus_watchdog

//--- logic/far_bus_responder.sv
`timescale 1ns/1ps
module far_bus_responder
	import bus_exc_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              srst,
	bus_exc_if.far                 bus,
	input  resp_type               mode,
	input  wire logic [WAIT_W-1:0] wait_cycles,
	input  wire logic              release_halt,
	input  wire logic              want_bus,
	input  wire logic [DATA_W-1:0] read_data,
	output logic                   owner
);
	logic [WAIT_W-1:0] cnt;
	logic              acted;
	logic              late;
	logic              late_retry;
	logic              retried;

	wire in_cycle  = !bus.addr_strobe_n;
	wire hit       = in_cycle && !acted && (cnt == wait_cycles);
	wire retry_md  = (mode == RESP_RETRY) || (mode == RESP_LATE_RETRY);
	// a retried access is answered normally so the rerun completes
	wire resp_type eff = (retried && retry_md) ? RESP_NORMAL : mode;
	wire do_ack   = hit && (eff == RESP_NORMAL || eff == RESP_HALT ||
	                        eff == RESP_LATE_FAULT || eff == RESP_LATE_RETRY);
	wire do_fault = (hit && (eff == RESP_FAULT || eff == RESP_RETRY)) || late;
	wire do_halt  = (hit && (eff == RESP_HALT || eff == RESP_RETRY)) || (late && late_retry);
	wire do_auto_vector_n  = hit && (eff == RESP_AUTOVEC);
	wire do_late  = hit && (eff == RESP_LATE_FAULT || eff == RESP_LATE_RETRY);
	wire next_own = want_bus && (owner || !bus.bus_grant_n);

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			cnt                 <= '0;
			acted               <= 1'b0;
			late                <= 1'b0;
			late_retry          <= 1'b0;
			retried             <= 1'b0;
			owner               <= 1'b0;
			bus.size_ack_n      <= ACK_NONE;
			bus.bus_fault_n     <= NEGATED;
			bus.halt_n          <= NEGATED;
			bus.auto_vector_n   <= NEGATED;
			bus.bus_req_n       <= NEGATED;
			bus.bus_grant_ack_n <= NEGATED;
			bus.data_in         <= '0;
		end
		else
		begin
			// all pins move on the rising edge only
			cnt        <= (in_cycle && !acted) ? WAIT_W'(cnt + 1'b1) : (in_cycle ? cnt : '0);
			acted      <= in_cycle && (acted || hit);
			late       <= do_late;
			late_retry <= do_late && (eff == RESP_LATE_RETRY);
			if (hit)
				retried <= retry_md && !retried;
			bus.data_in <= read_data;
			if (!in_cycle)
			begin
				// ack, fault and autovector drop one clock after the strobe negates, before the next cycle
				bus.size_ack_n    <= ACK_NONE;
				bus.bus_fault_n   <= NEGATED;
				bus.auto_vector_n <= NEGATED;
			end
			else
			begin
				if (do_ack)
					bus.size_ack_n <= ACK_PORT16;
				if (do_fault)
					bus.bus_fault_n <= ASSERTED;
				if (do_auto_vector_n)
					bus.auto_vector_n <= ASSERTED;
			end
			// halt never drops before the fault it came with
			if (do_halt)
				bus.halt_n <= ASSERTED;
			else if (!in_cycle && release_halt)
				bus.halt_n <= NEGATED;
			owner               <= next_own;
			bus.bus_req_n       <= !(want_bus && !next_own);
			bus.bus_grant_ack_n <= !next_own;
		end
	end
endmodule : far_bus_responder

//--- tb/bus_exc_properties.sv
`timescale 1ns/1ps
// ************
// termination checks on the shared bus
// ************
module bus_exc_properties
	import bus_exc_pkg::*;
(
	input wire logic              ref_clk,
	input wire logic              srst,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic              rw,
	input wire logic              addr_strobe_n,
	input wire logic              locked_cycle_n,
	input wire logic              bus_grant_n,
	input wire logic [ACK_W-1:0]  size_ack_n,
	input wire logic              bus_fault_n,
	input wire logic              halt_n
);
	logic [8:0]        low_cnt;
	logic              keep;
	logic [ADDR_W-1:0] keep_addr;
	logic              keep_rw;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	// saturates so a hung strobe cannot wrap back into range
	always_ff @(posedge ref_clk)
		if (srst || addr_strobe_n)
			low_cnt <= 9'h0;
		else if (low_cnt != 9'h1ff)
			low_cnt <= low_cnt + 9'h1;

	// access sent back for a retry
	always_ff @(posedge ref_clk)
		if (srst)
			keep <= 1'b0;
		else if (!addr_strobe_n && !bus_fault_n && !halt_n)
		begin
			keep      <= 1'b1;
			keep_addr <= addr;
			keep_rw   <= rw;
		end
		else if (!addr_strobe_n)
			keep <= 1'b0;

	a_bus_timeout: assert property (int'(low_cnt) <= TIMEOUT_CYCLES + 3)
		else $error("strobe held past bus timeout");
	a_ack_ends_cycle: assert property (
		!addr_strobe_n && size_ack_n != ACK_NONE && bus_fault_n && halt_n
		&& $past(size_ack_n) == ACK_NONE |=> !addr_strobe_n ##1 addr_strobe_n)
		else $error("acknowledged cycle not ended on time");
	a_fault_ends_cycle: assert property (
		!addr_strobe_n && !bus_fault_n && $past(bus_fault_n) && size_ack_n == ACK_NONE
		|-> ##[1:2] addr_strobe_n)
		else $error("faulted cycle not ended");
	a_halt_holds_bus: assert property (addr_strobe_n && !halt_n |=> addr_strobe_n)
		else $error("cycle started while halted");
	a_sync_before_rerun: assert property ($rose(halt_n) |-> addr_strobe_n [*3])
		else $error("rerun started without sync delay");
	a_rerun_same_access: assert property (
		keep && !addr_strobe_n |-> addr == keep_addr && rw == keep_rw)
		else $error("rerun access differs");
	a_lock_through_retry: assert property (
		!locked_cycle_n && !bus_fault_n && !halt_n |=> !locked_cycle_n)
		else $error("lock dropped during retry");
	a_grant_only_idle: assert property (!bus_grant_n |-> addr_strobe_n && locked_cycle_n)
		else $error("bus granted while busy or locked");
endmodule : bus_exc_properties

//--- tb/bus_cycle_exception_control_tb.sv
`timescale 1ns/1ps
module bus_cycle_exception_control_tb;
	import bus_exc_pkg::*;
	logic              ref_clk, srst, start, write, prefetch, lock_seq, exc;
	logic              word_used, word_flush, release_halt, want_bus;
	logic              busy, done, fault_exc, pend, owner;
	logic [ADDR_W-1:0] addr;
	logic [FC_W-1:0]   fc;
	logic [DATA_W-1:0] read_data, rdata;
	logic [WAIT_W-1:0] wait_cycles;
	resp_type          mode;
	outcome_type       outcome;
	int                n, cycles, err_total, samples_checked;
	resp_type          fmode [2] = '{RESP_FAULT, RESP_LATE_FAULT};
	resp_type          rmode [2] = '{RESP_RETRY, RESP_LATE_RETRY};

	bus_exc_if bus_exc_if_i ();
	cpu_bus_exception cpu_bus_exception_i (.ref_clk(ref_clk), .srst(srst),
		.bus(bus_exc_if_i.cpu), .start(start), .addr(addr), .fc(fc), .size(2'h1),
		.write(write), .wdata(16'h1234), .prefetch(prefetch), .lock_seq(lock_seq),
		.word_used(word_used), .word_flush(word_flush), .busy(busy), .done(done),
		.outcome(outcome), .rdata(rdata), .fault_exc(fault_exc),
		.prefetch_fault_pending(pend));
	far_bus_responder far_bus_responder_i (.ref_clk(ref_clk), .srst(srst),
		.bus(bus_exc_if_i.far), .mode(mode), .wait_cycles(wait_cycles),
		.release_halt(release_halt), .want_bus(want_bus), .read_data(read_data),
		.owner(owner));
	bus_exc_properties bus_exc_properties_i (.ref_clk(ref_clk), .srst(srst),
		.addr(bus_exc_if_i.addr), .rw(bus_exc_if_i.rw),
		.addr_strobe_n(bus_exc_if_i.addr_strobe_n),
		.locked_cycle_n(bus_exc_if_i.locked_cycle_n),
		.bus_grant_n(bus_exc_if_i.bus_grant_n), .size_ack_n(bus_exc_if_i.size_ack_n),
		.bus_fault_n(bus_exc_if_i.bus_fault_n), .halt_n(bus_exc_if_i.halt_n));

	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// ceiling well above the longest sequence of tests
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_total++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic launch(input resp_type m, input logic [ADDR_W-1:0] a);
		@(negedge ref_clk);
		mode = m;
		addr = a;
		start = 1'b1;
		@(negedge ref_clk);
		start = 1'b0;
	endtask : launch

	task automatic wait_done();
		n = 0;
		exc = 1'b0;
		while (done !== 1'b1 && n < 400)
		begin
			@(negedge ref_clk);
			exc |= fault_exc === 1'b1;
			n++;
		end
		check(n < 400, 1'b1);
	endtask : wait_done

	task automatic t_normal();
		read_data = 16'h5a3c;
		launch(RESP_NORMAL, 32'h1000);
		wait_done();
		check(outcome, OUT_NORMAL);
		check(rdata, 16'h5a3c);
		write = 1'b1;
		wait_cycles = 4'h0;
		launch(RESP_NORMAL, 32'h1002);
		wait_done();
		check(rdata, 16'h5a3c);
		write = 1'b0;
		wait_cycles = 4'h2;
		$display("normal test done");
	endtask : t_normal

	task automatic t_fault();
		read_data = 16'hdead;
		foreach (fmode[i])
		begin
			launch(fmode[i], 32'h2000);
			wait_done();
			check(outcome, OUT_FAULT);
			check(exc, 1'b1);
			check(rdata, 16'h5a3c);
		end
		$display("fault test done");
	endtask : t_fault

	task automatic t_timeout();
		launch(RESP_SILENT, 32'h3000);
		wait_done();
		check(n >= TIMEOUT_CYCLES, 1'b1);
		check(outcome, OUT_FAULT);
		launch(RESP_AUTOVEC, 32'h3002);
		wait_done();
		check(outcome, OUT_FAULT);
		fc = FC_CPU_SPACE;
		launch(RESP_AUTOVEC, 32'h3004);
		wait_done();
		check(outcome, OUT_NORMAL);
		fc = 3'h1;
		$display("timeout test done");
	endtask : t_timeout

	task automatic t_halt();
		release_halt = 1'b0;
		launch(RESP_HALT, 32'h4000);
		wait_done();
		check(outcome, OUT_HALT);
		repeat (8) @(negedge ref_clk);
		check(busy, 1'b1);
		release_halt = 1'b1;
		n = 0;
		while (busy !== 1'b0 && n < 50)
		begin
			@(negedge ref_clk);
			n++;
		end
		check(n < 50, 1'b1);
		$display("halt test done");
	endtask : t_halt

	task automatic t_retry();
		foreach (rmode[i])
		begin
			release_halt = 1'b0;
			launch(rmode[i], 32'h5000);
			repeat (8) @(negedge ref_clk);
			check(bus_exc_if_i.addr_strobe_n, 1'b1);
			release_halt = 1'b1;
			wait_done();
			check(outcome, OUT_NORMAL);
			check(exc, 1'b0);
		end
		$display("retry test done");
	endtask : t_retry

	task automatic t_relinquish();
		want_bus = 1'b1;
		launch(RESP_RETRY, 32'h6000);
		n = 0;
		while (owner !== 1'b1 && n < 50)
		begin
			@(negedge ref_clk);
			n++;
		end
		check(bus_exc_if_i.bus_grant_n, 1'b0);
		want_bus = 1'b0;
		wait_done();
		check(outcome, OUT_NORMAL);
		$display("relinquish test done");
	endtask : t_relinquish

	task automatic t_locked();
		lock_seq = 1'b1;
		want_bus = 1'b1;
		release_halt = 1'b0;
		launch(RESP_RETRY, 32'h7000);
		repeat (8) @(negedge ref_clk);
		check(bus_exc_if_i.locked_cycle_n, 1'b0);
		release_halt = 1'b1;
		wait_done();
		check(outcome, OUT_NORMAL);
		check(owner, 1'b0);
		launch(RESP_FAULT, 32'h7002);
		wait_done();
		check(exc, 1'b1);
		lock_seq = 1'b0;
		want_bus = 1'b0;
		$display("locked test done");
	endtask : t_locked

	task automatic t_prefetch(input logic use_it);
		prefetch = 1'b1;
		launch(RESP_FAULT, 32'h8000);
		prefetch = 1'b0;
		wait_done();
		check(exc, 1'b0);
		check(pend, 1'b1);
		word_used = use_it;
		word_flush = !use_it;
		exc = 1'b0;
		repeat (3)
		begin
			@(negedge ref_clk);
			word_used = 1'b0;
			word_flush = 1'b0;
			exc |= fault_exc === 1'b1;
		end
		check(exc, use_it);
		check(pend, 1'b0);
		$display("prefetch test done");
	endtask : t_prefetch

	initial
	begin
		{srst, start, write, prefetch, lock_seq} = 5'h10;
		{word_used, word_flush, want_bus, release_halt} = 4'h1;
		addr = 32'h0;
		fc = 3'h1;
		read_data = 16'h0;
		wait_cycles = 4'h2;
		mode = RESP_NORMAL;
		repeat (3) @(negedge ref_clk);
		srst = 1'b0;
		check(busy, 1'b0);
		check(bus_exc_if_i.addr_strobe_n, 1'b1);
		t_normal();
		t_fault();
		t_timeout();
		t_halt();
		t_retry();
		t_relinquish();
		t_locked();
		t_prefetch(1'b1);
		t_prefetch(1'b0);
		give_verdict();
	end
endmodule : bus_cycle_exception_control_tb
